/* File: csp_map.svh */
/*
  Register map, field masks and timing counts of the codec serial port.
  Assumes a 32-bit AXI4-Lite bus and a 250 MHz aclk.
*/
// Operation
// [R1] Port runs only while enable bit set
// [R2] Stop-in-idle halts port during CPU idle
// [R3] Loopback feeds data output into data input
// [R4] Clock direction bit: set input, clear output
// [R5] Edge bit picks change and sample edges
// [R6] Frame sync direction bit: set input, clear output
// [R7] Underflow mode set repeats last written word
// [R8] Underflow mode clear sends zero words
// [R9] Disabled slots: tri-state or drive zeros
// [R10] Justification: data with sync or one later
// [R11] Two-bit field selects the framing protocol
// [R12] Modes: multi, two-channel, link16, link20
// [R13] Unimplemented control bits read zero, ignore writes
`ifndef CSP_MAP_SVH
`define CSP_MAP_SVH
`define CSP_OFF_CTRL 8'h00
`define CSP_OFF_TX 8'h04
`define CSP_OFF_RX 8'h08
`define CSP_OFF_STAT 8'h0C
`define CSP_OFF_SLOT 8'h10
`define CSP_CTRL_MASK 16'hAFE3
`define CSP_CTRL_RST 16'h0000
`define CSP_SLOT_RST 4'hF
`define CSP_STAT_UNF_BIT 2
`define CSP_SLOT_W 16
`define CSP_SLOTS 4
`define CSP_FRAME_CYC 7'h48
`define CSP_LINK_FS_CYC 7'h10
`define CSP_SCK_HALF 3'h4
`define CSP_FIFO_DEPTH 8
`endif

/* File: csp_pkg.sv */
/*
  Types of the codec serial port: control word layout and frame modes.
  Assumes nothing of its surroundings.
*/
package csp_pkg;
  typedef enum logic [1:0] {
    CSP_FS_MULTI = 2'h0,
    CSP_FS_TWO = 2'h1,
    CSP_FS_LINK16 = 2'h2,
    CSP_FS_LINK20 = 2'h3
  } csp_fs_mode_e;
  typedef struct packed {
    logic port_enable;
    logic rsv14;
    logic stop_in_idle;
    logic rsv12;
    logic loopback_enable;
    logic serial_clock_direction;
    logic serial_clock_edge_select;
    logic frame_sync_direction;
    logic underflow_mode;
    logic data_out_idle_mode;
    logic data_justification;
    logic [2:0] rsv4_2;
    csp_fs_mode_e frame_sync_mode;
  } csp_ctrl_s;
endpackage

/* File: csp_port.sv */
/*
  Transmit FIFO and the codec serial port: AXI4-Lite registers, clock and
  frame generation or tracking, slot shifting. Assumes a 250 MHz aclk and
  that the pad ring resolves the three-signal pins.
*/
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "csp_map.svh"

module csp_fifo #(parameter int W = 16, parameter int D = 8) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  assign in_ready = cnt_q != (AW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];
  // storage only written on an accepted item
  always_ff @(posedge aclk) begin
    if (in_valid && in_ready) begin
      mem_q[wp_q] <= in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(in_valid && in_ready) - (AW+1)'(out_valid && out_ready);
    end
  end
endmodule

module csp_port import csp_pkg::*; (
  // clock, reset, core state
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cpu_idle,
  // axi4-lite write
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // serial link pins
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n,
  input wire logic frame_sync_pin_i,
  output logic frame_sync_pin_o,
  output logic frame_sync_pin_oe_n,
  input wire logic serial_data_in_pin,
  output logic serial_data_out_pin,
  output logic serial_data_out_pin_oe_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [15:0] ctrl_q, last_tx_q, sh_q, rx_sh_q, rx_word_q;
  logic [3:0] slot_en_q;
  csp_ctrl_s ctl;
  logic run, unf_q, rx_full_q;
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_pend, wr_go, rd_go, fifo_in_ready, fifo_out_valid, pop;
  logic [15:0] fifo_data;
  assign ctl = csp_ctrl_s'(ctrl_q);
  assign run = ctl.port_enable && !(ctl.stop_in_idle && cpu_idle); // R1 R2

  // write path holds a tx write until the fifo has room
  assign s_awready = !aw_have_q;
  assign s_wready = !w_have_q;
  assign wr_pend = aw_have_q && w_have_q && !bvalid_q;
  assign wr_go = wr_pend && (awaddr_q != `CSP_OFF_TX || fifo_in_ready);
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_awaddr;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        if (awaddr_q == `CSP_OFF_CTRL || awaddr_q == `CSP_OFF_TX ||
            awaddr_q == `CSP_OFF_STAT || awaddr_q == `CSP_OFF_SLOT) begin
          bresp_q <= 2'h0;
        end else begin
          bresp_q <= 2'h2;
        end
      end else if (s_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // software-held registers; masked so unused control bits stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CSP_CTRL_RST;
      slot_en_q <= `CSP_SLOT_RST;
      last_tx_q <= 16'h0000;
    end else if (wr_go) begin
      if (awaddr_q == `CSP_OFF_CTRL) begin
        ctrl_q <= {wstrb_q[1] ? wdata_q[15:8] : ctrl_q[15:8],
                   wstrb_q[0] ? wdata_q[7:0] : ctrl_q[7:0]} & `CSP_CTRL_MASK; // R13
      end else if (awaddr_q == `CSP_OFF_SLOT && wstrb_q[0]) begin
        slot_en_q <= wdata_q[3:0];
      end else if (awaddr_q == `CSP_OFF_TX) begin
        last_tx_q <= wdata_q[15:0]; // R7
      end
    end
  end

  csp_fifo #(.W(16), .D(`CSP_FIFO_DEPTH)) u_txq (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(wr_pend && awaddr_q == `CSP_OFF_TX),
    .in_ready(fifo_in_ready),
    .in_data(wdata_q[15:0]),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // read path, one outstanding read
  assign s_arready = !rvalid_q;
  assign rd_go = s_arvalid && s_arready;
  assign s_rvalid = rvalid_q;
  assign s_rdata = rdata_q;
  assign s_rresp = rresp_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= 2'h0;
      if (s_araddr == `CSP_OFF_CTRL) begin
        rdata_q <= {16'h0000, ctrl_q};
      end else if (s_araddr == `CSP_OFF_TX) begin
        rdata_q <= 32'h0;
      end else if (s_araddr == `CSP_OFF_RX) begin
        rdata_q <= {16'h0000, rx_word_q};
      end else if (s_araddr == `CSP_OFF_STAT) begin
        rdata_q <= {28'h0, rx_full_q, unf_q, !fifo_in_ready, !fifo_out_valid};
      end else if (s_araddr == `CSP_OFF_SLOT) begin
        rdata_q <= {28'h0, slot_en_q};
      end else begin
        rdata_q <= 32'h0;
        rresp_q <= 2'h2;
      end
    end else if (s_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // pin inputs: three flops, level moves once stages two and three agree
  logic [2:0] pin_in, filt_q;
  logic [2:0] sync_q [3];
  assign pin_in = {serial_data_in_pin, frame_sync_pin_i, serial_clock_pin_i};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync_q[i] <= 3'h0;
        filt_q[i] <= 1'b0;
      end else begin
        sync_q[i] <= {sync_q[i][1:0], pin_in[i]};
        if (sync_q[i][1] == sync_q[i][2]) begin
          filt_q[i] <= sync_q[i][2];
        end
      end
    end
  end

  // master clock divider; frozen while halted
  logic [2:0] div_q;
  logic mclk_q, clk_prev_q, clk_now, rise, fall, change_e, samp_e;
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl.port_enable) begin
      div_q <= 3'h0;
      mclk_q <= 1'b0;
    end else if (run) begin
      if (div_q == `CSP_SCK_HALF - 3'h1) begin
        div_q <= 3'h0;
        mclk_q <= !mclk_q;
      end else begin
        div_q <= div_q + 3'h1;
      end
    end
  end
  assign clk_now = ctl.serial_clock_direction ? filt_q[0] : mclk_q; // R4
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_now;
    end
  end
  assign rise = run && clk_now && !clk_prev_q;
  assign fall = run && !clk_now && clk_prev_q;
  assign change_e = ctl.serial_clock_edge_select ? fall : rise; // R5
  assign samp_e = ctl.serial_clock_edge_select ? rise : fall; // R5

  // frame position; a seen sync start resynchronises the count
  logic [6:0] cnt_q, cnt_d, bp_d, bp_s, off;
  logic fs_o_q, fs_prev_q, fs_seen_q, fs_lvl, tx_on, rx_on, rx_take;
  logic [1:0] nslot;
  assign fs_lvl = ctl.frame_sync_direction ? filt_q[1] : fs_o_q; // R6
  assign cnt_d = fs_seen_q ? 7'h01 : (cnt_q == `CSP_FRAME_CYC - 7'h1) ? 7'h00 : cnt_q + 7'h1;
  assign off = {6'h00, !ctl.data_justification}; // R10
  assign bp_d = cnt_d - off;
  assign bp_s = cnt_q - off;
  assign nslot = (ctl.frame_sync_mode == CSP_FS_TWO) ? 2'h1 : 2'h3; // R11 R12
  assign tx_on = bp_d[6] == 1'b0 && bp_d[5:4] <= nslot && slot_en_q[bp_d[5:4]];
  assign rx_on = bp_s[6] == 1'b0 && bp_s[5:4] <= nslot && slot_en_q[bp_s[5:4]];
  assign rx_take = samp_e && rx_on;
  assign pop = change_e && tx_on && bp_d[3:0] == 4'h0 && fifo_out_valid;
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl.port_enable) begin
      cnt_q <= 7'h00;
      fs_o_q <= 1'b0;
      fs_prev_q <= 1'b0;
      fs_seen_q <= 1'b0;
    end else begin
      if (samp_e) begin
        fs_prev_q <= fs_lvl;
        fs_seen_q <= fs_lvl && !fs_prev_q;
      end else if (change_e) begin
        fs_seen_q <= 1'b0;
      end
      if (change_e) begin
        cnt_q <= cnt_d;
        // link modes hold sync high for a whole first slot
        fs_o_q <= cnt_d == 7'h00 || (ctl.frame_sync_mode[1] && cnt_d < `CSP_LINK_FS_CYC);
      end
    end
  end

  // transmit shifter, msb first; loads at the boundary of each enabled slot
  logic unf_hit;
  assign unf_hit = change_e && tx_on && bp_d[3:0] == 4'h0 && !fifo_out_valid;
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctl.port_enable) begin
      sh_q <= 16'h0000;
      serial_data_out_pin_oe_n <= 1'b1;
    end else if (change_e) begin
      serial_data_out_pin_oe_n <= !(tx_on || !ctl.data_out_idle_mode); // R9
      if (!tx_on) begin
        sh_q <= 16'h0000; // R9
      end else if (bp_d[3:0] != 4'h0) begin
        sh_q <= {sh_q[14:0], 1'b0};
      end else if (fifo_out_valid) begin
        sh_q <= fifo_data;
      end else begin
        sh_q <= ctl.underflow_mode ? last_tx_q : 16'h0000; // R7 R8
      end
    end
  end
  assign serial_data_out_pin = sh_q[15];

  // sticky underflow, cleared by writing one; a new underflow wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unf_q <= 1'b0;
    end else if (unf_hit) begin
      unf_q <= 1'b1;
    end else if (wr_go && awaddr_q == `CSP_OFF_STAT && wdata_q[`CSP_STAT_UNF_BIT]) begin
      unf_q <= 1'b0;
    end
  end

  // receive shifter; loopback takes the output bit instead of the pin
  logic sdi_eff;
  assign sdi_eff = ctl.loopback_enable ? serial_data_out_pin : filt_q[2]; // R3
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sh_q <= 16'h0000;
      rx_word_q <= 16'h0000;
      rx_full_q <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_sh_q <= {rx_sh_q[14:0], sdi_eff};
      end
      if (rx_take && bp_s[3:0] == 4'hF) begin
        rx_word_q <= {rx_sh_q[14:0], sdi_eff};
        rx_full_q <= 1'b1;
      end else if (rd_go && s_araddr == `CSP_OFF_RX) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  // pin drivers; a disabled port releases everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_clock_pin_oe_n <= 1'b1;
      frame_sync_pin_oe_n <= 1'b1;
    end else begin
      serial_clock_pin_oe_n <= !(ctl.port_enable && !ctl.serial_clock_direction); // R1 R4
      frame_sync_pin_oe_n <= !(ctl.port_enable && !ctl.frame_sync_direction); // R1 R6
    end
  end
  assign serial_clock_pin_o = mclk_q;
  assign frame_sync_pin_o = fs_o_q;

  sequence s_slot_load;
    change_e && tx_on && bp_d[3:0] == 4'h0;
  endsequence
  sequence s_sync_seen;
    change_e && fs_seen_q;
  endsequence
  chk_off_release: assert property (!ctl.port_enable |=> // R1
    serial_clock_pin_oe_n && frame_sync_pin_oe_n && serial_data_out_pin_oe_n)
    else $error("pins driven while port disabled");
  chk_idle_freeze: assert property (ctl.port_enable && ctl.stop_in_idle && cpu_idle |=> // R2
    $stable(cnt_q))
    else $error("frame moved during idle halt");
  chk_loop_path: assert property (ctl.loopback_enable && rx_take |=> // R3
    rx_sh_q[0] == $past(serial_data_out_pin))
    else $error("loopback bit not taken from output");
  chk_clock_dir: assert property (ctl.port_enable |=> // R4
    serial_clock_pin_oe_n == $past(ctl.serial_clock_direction))
    else $error("clock pin direction wrong");
  chk_change_edge: assert property ($changed(sh_q) && $past(ctl.port_enable) |-> // R5
    $past(ctl.serial_clock_edge_select ? fall : rise))
    else $error("data changed on wrong edge");
  chk_sync_dir: assert property (ctl.port_enable |=> // R6
    frame_sync_pin_oe_n == $past(ctl.frame_sync_direction))
    else $error("sync pin direction wrong");
  chk_unf_repeat: assert property (s_slot_load ##0 !fifo_out_valid && ctl.underflow_mode // R7
    |=> sh_q == $past(last_tx_q))
    else $error("underflow did not repeat last word");
  chk_unf_zero: assert property (s_slot_load ##0 !fifo_out_valid && !ctl.underflow_mode // R8
    |=> sh_q == 16'h0000)
    else $error("underflow did not send zeros");
  chk_idle_slot: assert property (change_e && !tx_on |=> sh_q == 16'h0000 && // R9
    serial_data_out_pin_oe_n == $past(ctl.data_out_idle_mode))
    else $error("disabled slot output wrong");
  chk_sync_align: assert property (s_sync_seen |=> cnt_q == 7'h01) // R10
    else $error("frame not aligned to sync");
  chk_two_chan: assert property (ctl.frame_sync_mode == CSP_FS_TWO && bp_d[5] // R11 R12
    |-> !tx_on)
    else $error("slot beyond two channels active");
  chk_ctrl_rsv: assert property ((ctrl_q & ~`CSP_CTRL_MASK) == 16'h0000) // R13
    else $error("unimplemented control bit set");
endmodule

/* File: csp_codec_model.sv */
/*
  Behavioural codec on the far side of the serial link: supplies clock,
  frame sync and data in slave mode. Assumes the bench resolves the pins.
*/
`timescale 1ns/10ps
module csp_codec_model (
  // control from the bench
  input wire logic run,
  input wire logic edge_sel,
  input wire logic just,
  input wire logic [15:0] word,
  // link pins
  output logic sck,
  output logic fs,
  output logic sdi
);
  int cyc = 71;
  int pos;
  // one process owns every link line, so each has a single driver;
  // clock runs only while a run is on, parked low between runs
  initial begin
    sck = 1'b0;
    fs = 1'b0;
    sdi = 1'b0;
    forever begin
      #16;
      if (run) sck = ~sck;
      else sck = 1'b0;
      // drive on the change edge so the port samples a settled level
      if (run && (sck ^ edge_sel)) begin
        cyc = (cyc == 71) ? 0 : cyc + 1;
        fs = (cyc == 0);
        pos = just ? cyc : cyc - 1;
        if (pos >= 0 && pos < 64) sdi = word[15 - pos % 16];
        else sdi = ~sdi; // no held level outside slots
      end
    end
  end
endmodule

/* File: codec_serial_port_control_tb.sv */
/*
  Self-checking bench of the codec serial port: registers, pin directions,
  framing, idle gating, loopback, underflow and slave reception.
  Assumes the design sources and the codec model are compiled first.
*/
`timescale 1ns/10ps
module codec_serial_port_control_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic cpu_idle = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic sck_o, sck_oe_n, fs_o, fs_oe_n, sdo, sdo_oe_n;
  logic m_run = 1'b0, m_esel = 1'b0, m_just = 1'b0;
  logic [15:0] m_word = 16'h0;
  logic [15:0] dir[4] = '{16'h0000, 16'h8000, 16'h8400, 16'h8100};
  wire m_sck, m_fs, m_sdi;
  // pin level: whoever has the pin enabled drives it
  wire sck_w = sck_oe_n ? m_sck : sck_o;
  wire fs_w = fs_oe_n ? m_fs : fs_o;
  int err_count = 0, checks_done = 0;
  int seed = 32'h56955B55;
  logic [33:0] rq[$];
  logic [1:0] bq[$];

  // 250 MHz core clock
  always #2 aclk = ~aclk;

  csp_port i_csp_port (
    .aclk(aclk), .aresetn(aresetn), .cpu_idle(cpu_idle),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe_n(sck_oe_n), .frame_sync_pin_i(fs_w),
    .frame_sync_pin_o(fs_o), .frame_sync_pin_oe_n(fs_oe_n),
    .serial_data_in_pin(m_sdi), .serial_data_out_pin(sdo),
    .serial_data_out_pin_oe_n(sdo_oe_n)
  );

  csp_codec_model i_csp_codec_model (
    .run(m_run), .edge_sel(m_esel), .just(m_just), .word(m_word),
    .sck(m_sck), .fs(m_fs), .sdi(m_sdi)
  );

  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic hang;
    err_count++;
    give_verdict;
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // one write; address and data offered together, bready held up
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 300) hang;
  endtask

  // one read; the expected word and response are queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    rq.push_back({er, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 300) hang;
  endtask

  // counts over n cycles: clock toggles, sync high, data driven, data not a driven zero
  task automatic count(input int n, input int sel, output int c);
    logic p;
    c = 0;
    p = sck_o;
    repeat (n) begin
      @(posedge aclk);
      case (sel)
        0: c += (sck_o !== p);
        1: c += (fs_o === 1'b1);
        2: c += (sdo_oe_n !== 1'b1);
        default: c += (sdo !== 1'b0 || sdo_oe_n !== 1'b0);
      endcase
      p = sck_o;
    end
  endtask

  // monitor: every answer is compared with the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) check("read", {rresp, rdata}, rq.pop_front());
    if (bvalid && bready) check("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
  end

  // main sequence
  initial begin
    int c;
    int m;
    logic [15:0] w;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h10, 32'hF, 2'h0);
    rd(8'h0C, 32'h1, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
    wr(8'h00, 32'hFFFF, 2'h0);
    rd(8'h00, 32'hAFE3, 2'h0);
    done("registers");
    foreach (dir[i]) begin
      wr(8'h00, {16'h0, dir[i]}, 2'h0);
      cyc(2);
      check("clock oe", sck_oe_n, !dir[i][15] | dir[i][10]);
      check("sync oe", fs_oe_n, !dir[i][15] | dir[i][8]);
    end
    done("directions");
    // a window of one frame holds exactly one whole sync pulse
    for (m = 0; m < 4; m++) begin
      wr(8'h00, 32'h8000 | m, 2'h0);
      rd(8'h00, 32'h8000 | m, 2'h0);
      cyc(600);
      count(576, 1, c);
      check("sync width", c, m[1] ? 128 : 8);
    end
    done("frame modes");
    for (m = 0; m < 3; m++) begin
      cpu_idle <= (m != 1);
      wr(8'h00, (m == 2) ? 32'h8000 : 32'hA000, 2'h0);
      cyc(8);
      count(40, 0, c);
      check("clock toggles", c, (m == 0) ? 0 : 10);
    end
    cpu_idle <= 1'b0;
    done("idle");
    wr(8'h10, 32'h0, 2'h0);
    wr(8'h00, 32'h8040, 2'h0);
    // outputs only move on a change edge, up to eight cycles away
    cyc(12);
    count(576, 2, c);
    check("driven cycles", c, 0);
    wr(8'h00, 32'h8000, 2'h0);
    cyc(12);
    count(576, 3, c);
    check("non zero cycles", c, 0);
    wr(8'h10, 32'hF, 2'h0);
    done("disabled slots");
    // one word then underflow: repeated, then zero filled
    w = 16'($random(seed));
    wr(8'h00, 32'h0, 2'h0);
    wr(8'h04, {16'h0, w}, 2'h0);
    wr(8'h00, 32'h8880, 2'h0);
    cyc(1200);
    rd(8'h08, {16'h0, w}, 2'h0);
    wr(8'h00, 32'h8800, 2'h0);
    cyc(1200);
    rd(8'h08, 32'h0, 2'h0);
    wr(8'h00, 32'h0, 2'h0);
    // port stopped: receive flag settles, sticky underflow waits for a one
    rd(8'h08, 32'h0, 2'h0);
    rd(8'h0C, 32'h5, 2'h0);
    wr(8'h0C, 32'h4, 2'h0);
    rd(8'h0C, 32'h1, 2'h0);
    done("loopback");
    // slave: codec supplies clock and sync, every edge and alignment
    for (m = 0; m < 4; m++) begin
      m_esel <= m[0];
      m_just <= m[1];
      m_word <= 16'($random(seed));
      m_run <= 1'b1;
      wr(8'h00, 32'h8500 | (m[0] << 9) | (m[1] << 5), 2'h0);
      cyc(1800);
      rd(8'h08, {16'h0, m_word}, 2'h0);
      m_run <= 1'b0;
      wr(8'h00, 32'h0, 2'h0);
    end
    done("slave receive");
    give_verdict;
  end
endmodule
